// >>> vectored_interrupt_controller_tb.sv
`timescale 1ns/1ps
`default_nettype none
module vectored_interrupt_controller_tb;
  import vic_pkg::*;
  logic core_clk, rst_n, wdt, lvl_on, lvl_we, lvl_clr, bnd, trap, vvalid;
  logic [15:0] vdata, pc, stat, trap_vec, lvl_wd, raddr, npc, nstat;
  logic [15:0] ra1, ra2, ss1, ss2;
  logic [3:0] seg, nseg, sg1, sg2, cur_lvl;
  logic [2:0] lvl_idx, delay;
  logic [63:0] irq, en, pend;
  logic [127:0] lvls;
  logic busy, req, load;
  int mismatches, compares;

  vic_top u_dut (.core_clk(core_clk), .rst_n(rst_n),
    .watchdog_event_source(wdt), .irq_req(irq), .source_enable_bits(en),
    .level_ctrl_on(lvl_on), .lvl_wr_en(lvl_we), .lvl_wr_idx(lvl_idx),
    .lvl_wr_data(lvl_wd), .cil_clear(lvl_clr), .instr_boundary(bnd),
    .pc_in(pc), .csr_in(seg), .psw_in(stat), .soft_trap_instr(trap),
    .soft_trap_vec_addr(trap_vec), .vec_rd_valid(vvalid),
    .vec_rd_data(vdata), .busy_q(busy), .vec_rd_req_q(req),
    .vec_rd_addr_q(raddr), .entry_load_q(load), .new_pc_q(npc),
    .new_psw_q(nstat), .new_csr_q(nseg), .return_addr_save_lvl1_q(ra1),
    .return_addr_save_lvl2_q(ra2), .segment_save_lvl1_q(sg1),
    .segment_save_lvl2_q(sg2), .status_save_lvl1_q(ss1),
    .status_save_lvl2_q(ss2), .current_level_reg_q(cur_lvl),
    .pending_regs_q(pend), .level_select_regs(lvls));

  vic_core_model u_core (.core_clk(core_clk), .rst_n(rst_n),
    .vec_rd_req_q(req), .vec_rd_addr_q(raddr), .delay(delay),
    .vec_rd_valid(vvalid), .vec_rd_data(vdata));

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  // ****
  // helpers
  // ****
  task automatic close_out;
    $display("mismatches=%0d compares=%0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t got %0h exp %0h", $time, got, exp);
    end
  endtask : chk

  task automatic wait_for(input logic ld);
    for (int i = 0; i < 40 && (ld ? load : req) !== 1'b1; i++) begin
      @(negedge core_clk);
    end
    if ((ld ? load : req) !== 1'b1) begin
      mismatches++;
      close_out();
    end
  endtask : wait_for

  function automatic logic [15:0] vec(input int n);
    vec = 16'h0008 + 16'(2 * (n - 1));
  endfunction : vec

  function automatic logic [63:0] src(input int n);
    src = 64'h1 << (n + 3);
  endfunction : src

  task automatic fire(input logic [63:0] m, input logic w);
    irq = m;
    wdt = w;
    @(negedge core_clk);
    irq = '0;
    wdt = 1'b0;
  endtask : fire

  task automatic wr_lvl(input logic [2:0] idx, input logic [15:0] d);
    lvl_idx = idx;
    lvl_wd = d;
    lvl_we = 1'b1;
    @(negedge core_clk);
    lvl_we = 1'b0;
  endtask : wr_lvl

  // one full entry with its saves and loaded values
  task automatic entry(input logic [15:0] va, input logic nmi);
    logic [15:0] ns;
    ns = {stat[15:4], nmi & stat[3], stat[2], nmi ? 2'h2 : 2'h1};
    wait_for(1'b0);
    chk(raddr, va);
    wait_for(1'b1);
    chk(npc, va ^ 16'h5a5a);
    chk(nstat, ns);
    chk(nseg, 4'h0);
    chk(nmi ? ra2 : ra1, pc);
    chk(nmi ? ss2 : ss1, stat);
    chk(nmi ? sg2 : sg1, seg);
    @(negedge core_clk);
  endtask : entry

  // ****
  // sequence
  // ****
  initial begin
    {wdt, lvl_on, lvl_we, lvl_clr, trap, rst_n} = '0;
    bnd = 1'b1;
    pc = 16'h1234;
    stat = 16'h0a40;
    seg = 4'h5;
    trap_vec = 16'h0040;
    {lvl_idx, lvl_wd, delay, irq, en} = '0;
    mismatches = 0;
    compares = 0;
    repeat (6) @(negedge core_clk);
    rst_n = 1'b1;
    chk(pend, 64'h0);
    chk(lvls, 128'h0);
    fire(64'h0, 1'b1);
    entry(16'h0008, 1'b1);
    stat = 16'h0a48;
    fire(src(3), 1'b0);
    repeat (5) @(negedge core_clk);
    chk(busy, 1'b0);
    chk(pend[6], 1'b1);
    en = '1;
    stat = 16'h0a40;
    repeat (5) @(negedge core_clk);
    chk(busy, 1'b0);
    chk(pend[6], 1'b1);
    stat = 16'h0a48;
    bnd = 1'b0;
    repeat (5) @(negedge core_clk);
    chk(pend[6], 1'b1);
    bnd = 1'b1;
    entry(vec(3), 1'b0);
    chk(pend[6], 1'b0);
    delay = 3'h3;
    fire(src(10) | src(60), 1'b0);
    entry(vec(10), 1'b0);
    chk(pend[63], 1'b1);
    entry(vec(60), 1'b0);
    wr_lvl(3'h7, 16'hc000);
    chk(lvls, 128'h0);
    lvl_on = 1'b1;
    lvl_clr = 1'b1;
    repeat (4) @(negedge core_clk);
    lvl_clr = 1'b0;
    wr_lvl(3'h7, 16'hc000);
    chk(lvls[127:112], 16'hc000);
    fire(src(10) | src(60), 1'b0);
    entry(vec(60), 1'b0);
    chk(cur_lvl, 4'h8);
    repeat (6) @(negedge core_clk);
    chk(pend[13], 1'b1);
    lvl_clr = 1'b1;
    @(negedge core_clk);
    lvl_clr = 1'b0;
    entry(vec(10), 1'b0);
    chk(cur_lvl, 4'h1);
    lvl_on = 1'b0;
    delay = 3'h0;
    fire(src(5), 1'b1);
    entry(16'h0008, 1'b1);
    entry(vec(5), 1'b0);
    delay = 3'h3;
    fire(src(6), 1'b0);
    wait_for(1'b0);
    fire(src(4), 1'b1);
    entry(vec(6), 1'b0);
    entry(16'h0008, 1'b1);
    chk(pend[7], 1'b1);
    entry(vec(4), 1'b0);
    trap = 1'b1;
    wait_for(1'b0);
    trap = 1'b0;
    entry(trap_vec, 1'b0);
    close_out();
  end
endmodule : vectored_interrupt_controller_tb
`default_nettype wire

// >>> vic_arbiter.sv
`timescale 1ns/1ps
`default_nettype none
module vic_arbiter (
  input wire logic [vic_pkg::IMG_W-1:0] cand,
  input wire logic [2*vic_pkg::IMG_W-1:0] levels,
  input wire logic level_on,
  output logic win_valid,
  output logic [5:0] win_bit,
  output logic [1:0] win_lvl
);
  import vic_pkg::*;

  // scan downward so the lowest bit wins every tie
  always_comb begin
    logic [1:0] l;
    l = 2'h0;
    win_valid = 1'b0;
    win_bit = 6'h00;
    win_lvl = 2'h0;
    for (int i = IMG_W - 1; i >= 0; i--) begin
      l = level_on ? levels[2*i +: 2] : 2'h0;
      if (cand[i] && (!win_valid || l >= win_lvl)) begin
        win_valid = 1'b1;
        win_bit = 6'(i);
        win_lvl = l;
      end
    end
  end

endmodule : vic_arbiter
`default_nettype wire

// >>> vic_core_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// vector table side of the core
// ****
module vic_core_model (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic vec_rd_req_q,
  input wire logic [15:0] vec_rd_addr_q,
  input wire logic [2:0] delay,
  output logic vec_rd_valid,
  output logic [15:0] vec_rd_data
);
  logic [2:0] cnt;
  // data line toggles when no answer stands
  always @(negedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 3'h0;
      vec_rd_valid <= 1'b0;
      vec_rd_data <= 16'h0000;
    end else if (vec_rd_req_q && !vec_rd_valid && cnt == delay) begin
      vec_rd_valid <= 1'b1;
      vec_rd_data <= vec_rd_addr_q ^ 16'h5a5a;
    end else begin
      cnt <= (vec_rd_req_q && !vec_rd_valid) ? cnt + 3'h1 : 3'h0;
      vec_rd_valid <= 1'b0;
      vec_rd_data <= ~vec_rd_data;
    end
  end
endmodule : vic_core_model
`default_nettype wire

// >>> vic_level_regs.sv
`timescale 1ns/1ps
`default_nettype none
module vic_level_regs (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic level_ctrl_on,
  input wire logic lvl_wr_en,
  input wire logic [2:0] lvl_wr_idx,
  input wire logic [vic_pkg::LVL_REG_W-1:0] lvl_wr_data,
  output logic [2*vic_pkg::IMG_W-1:0] level_select_regs
);
  import vic_pkg::*;

  logic [LVL_REG_W-1:0] lvl_q [NUM_LVL_REGS];
  wire lvl_wr_ok = lvl_wr_en && level_ctrl_on;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int k = 0; k < NUM_LVL_REGS; k++) lvl_q[k] <= LVL_RESET;
    end else if (lvl_wr_ok) begin
      lvl_q[lvl_wr_idx] <= lvl_wr_data;
    end
  end

  always_comb begin
    for (int k = 0; k < NUM_LVL_REGS; k++) begin
      level_select_regs[LVL_REG_W*k +: LVL_REG_W] = lvl_q[k];
    end
  end

endmodule : vic_level_regs
`default_nettype wire

// >>> vic_pkg.sv
package vic_pkg;

  // ****************************************************************
  // request image and vectors
  // ****************************************************************
  localparam int IMG_W = 64;
  localparam int BIT_W = 6;
  localparam int LVL_W = 2;
  localparam int NUM_LVL_REGS = 8;
  localparam int LVL_REG_W = 16;
  localparam logic [5:0] WDT_BIT = 6'h00;
  localparam logic [5:0] FIRST_MASK_BIT = 6'h06;
  localparam logic [5:0] BIT_TO_SRC_OFS = 6'h03;
  localparam logic [IMG_W-1:0] MASKABLE_BITS = 64'hffff_ffff_ffff_ffc0;
  localparam logic [15:0] NMI_VECTOR = 16'h0008;
  localparam logic [15:0] VEC_BASE = 16'h0008;
  localparam logic [IMG_W-1:0] PEND_RESET = 64'h0000_0000_0000_0000;
  localparam logic [LVL_REG_W-1:0] LVL_RESET = 16'h0000;

  // ****************************************************************
  // status word fields
  // ****************************************************************
  localparam int PSW_DEPTH_LSB = 0;
  localparam int PSW_MIE_BIT = 3;
  localparam logic [1:0] DEPTH_MASKABLE = 2'h1;
  localparam logic [1:0] DEPTH_NMI = 2'h2;
  localparam logic [3:0] CSR_ENTRY = 4'h0;
  localparam logic [3:0] CIL_RESET = 4'h0;

  typedef enum logic [1:0] {VIC_IDLE, VIC_FETCH, VIC_LOAD} vic_state_t;

  // source number n sits at image bit n+3 (bit 8k+j = reg k, bit j)
  function automatic logic [5:0] vic_src_of_bit(input logic [5:0] b);
    vic_src_of_bit = b - BIT_TO_SRC_OFS;
  endfunction : vic_src_of_bit

  // vector address = base + 2*(n-1)
  function automatic logic [15:0] vic_vec_of_src(input logic [5:0] n);
    vic_vec_of_src = VEC_BASE + {9'h000, n - 6'h01, 1'b0};
  endfunction : vic_vec_of_src

endpackage : vic_pkg

// >>> vic_top.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - maskable needs source enable and master enable
// - watchdog is non-maskable, source 1, vector 0x0008
// - level control off: lowest source number wins
// - level control on: highest level, then lowest number
// - accepted request fetches vector, starts entry
// - vector equals 0x0008 plus 2*(n-1)
// - source n sits at register bit n+3
// - watchdog beats everything, others held
// - maskable entry saves pc, status to level 1
// - maskable entry: depth 1, master off, segment 0
// - segment save/reset only above 64Kbyte memory
// - watchdog entry saves to level 2, depth 2
// - soft trap runs level-1 entry, own vector
// - level code 00 lowest up to 11 highest
// - level registers reset zero, written only when on
module vic_top #(
  parameter bit PROG_MEM_LARGE = 1'b1
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic watchdog_event_source,
  input wire logic [vic_pkg::IMG_W-1:0] irq_req,
  input wire logic [vic_pkg::IMG_W-1:0] source_enable_bits,
  input wire logic level_ctrl_on,
  input wire logic lvl_wr_en,
  input wire logic [2:0] lvl_wr_idx,
  input wire logic [vic_pkg::LVL_REG_W-1:0] lvl_wr_data,
  input wire logic cil_clear,
  input wire logic instr_boundary,
  input wire logic [15:0] pc_in,
  input wire logic [3:0] csr_in,
  input wire logic [15:0] psw_in,
  input wire logic soft_trap_instr,
  input wire logic [15:0] soft_trap_vec_addr,
  input wire logic vec_rd_valid,
  input wire logic [15:0] vec_rd_data,
  output logic busy_q,
  output logic vec_rd_req_q,
  output logic [15:0] vec_rd_addr_q,
  output logic entry_load_q,
  output logic [15:0] new_pc_q,
  output logic [15:0] new_psw_q,
  output logic [3:0] new_csr_q,
  output logic [15:0] return_addr_save_lvl1_q,
  output logic [15:0] return_addr_save_lvl2_q,
  output logic [3:0] segment_save_lvl1_q,
  output logic [3:0] segment_save_lvl2_q,
  output logic [15:0] status_save_lvl1_q,
  output logic [15:0] status_save_lvl2_q,
  output logic [3:0] current_level_reg_q,
  output logic [vic_pkg::IMG_W-1:0] pending_regs_q,
  output logic [2*vic_pkg::IMG_W-1:0] level_select_regs
);
  import vic_pkg::*;

  // ****************************************************************
  // level registers and arbitration
  // ****************************************************************
  vic_level_regs u_lvl (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .level_ctrl_on(level_ctrl_on),
    .lvl_wr_en(lvl_wr_en),
    .lvl_wr_idx(lvl_wr_idx),
    .lvl_wr_data(lvl_wr_data),
    .level_select_regs(level_select_regs)
  );

  vic_state_t state_q, state_d;
  logic win_valid;
  logic [5:0] win_bit;
  logic [1:0] win_lvl;
  logic [2:0] cil_top;

  wire master_irq_enable = psw_in[PSW_MIE_BIT];
  wire [IMG_W-1:0] cand =
    pending_regs_q & source_enable_bits & MASKABLE_BITS;

  vic_arbiter u_arb (
    .cand(cand),
    .levels(level_select_regs),
    .level_on(level_ctrl_on),
    .win_valid(win_valid),
    .win_bit(win_bit),
    .win_lvl(win_lvl)
  );

  // highest level in service plus one, 0 when none
  always_comb begin
    cil_top = 3'h0;
    for (int i = 0; i < 4; i++) begin
      if (current_level_reg_q[i]) cil_top = 3'(i + 1);
    end
  end

  // independent winner check: nobody outranks the chosen source
  logic lvl_beaten;
  always_comb begin
    logic [1:0] li;
    li = 2'h0;
    lvl_beaten = 1'b0;
    for (int i = 0; i < IMG_W; i++) begin
      li = level_select_regs[2*i +: 2];
      if (cand[i] && (li > win_lvl ||
          (li == win_lvl && 6'(i) < win_bit))) begin
        lvl_beaten = 1'b1;
      end
    end
  end

  // ****************************************************************
  // acceptance
  // ****************************************************************
  wire idle = (state_q == VIC_IDLE);
  wire at_edge = idle && instr_boundary;
  wire lvl_ok = !level_ctrl_on || ({1'b0, win_lvl} + 3'h1 > cil_top);
  wire take_nmi = at_edge && pending_regs_q[WDT_BIT];
  wire take_trap = at_edge && !pending_regs_q[WDT_BIT] && soft_trap_instr;
  wire take_mask = at_edge && !pending_regs_q[WDT_BIT] && !soft_trap_instr
    && win_valid && master_irq_enable && lvl_ok;
  wire take_lvl1 = take_trap || take_mask;
  wire take_any = take_nmi || take_lvl1;
  wire [15:0] mask_vec = vic_vec_of_src(vic_src_of_bit(win_bit));
  wire [15:0] sel_vec = take_nmi ? NMI_VECTOR :
    (take_trap ? soft_trap_vec_addr : mask_vec);

  wire [15:0] psw_lvl1 = {psw_in[15:PSW_MIE_BIT+1], 1'b0,
    psw_in[PSW_MIE_BIT-1:PSW_DEPTH_LSB+2], DEPTH_MASKABLE};
  wire [15:0] psw_lvl2 = {psw_in[15:PSW_DEPTH_LSB+2], DEPTH_NMI};

  // ****************************************************************
  // pending image: set beats the entry clear
  // ****************************************************************
  wire [IMG_W-1:0] win_onehot = IMG_W'(1) << win_bit;
  wire [IMG_W-1:0] pend_clr =
    (take_nmi ? IMG_W'(1) : '0) | (take_mask ? win_onehot : '0);
  wire [IMG_W-1:0] pend_set =
    (irq_req & MASKABLE_BITS) | IMG_W'(watchdog_event_source);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) pending_regs_q <= PEND_RESET;
    else pending_regs_q <= (pending_regs_q & ~pend_clr) | pend_set;
  end

  // ****************************************************************
  // current level: clear drops highest, maskable entry sets its level
  // ****************************************************************
  wire [3:0] cil_drop = (cil_clear && cil_top != 3'h0) ?
    4'(4'h1 << (cil_top - 3'h1)) : 4'h0;
  wire [3:0] cil_add = (take_mask && level_ctrl_on) ?
    4'(4'h1 << win_lvl) : 4'h0;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) current_level_reg_q <= CIL_RESET;
    else current_level_reg_q <= (current_level_reg_q & ~cil_drop) | cil_add;
  end

  // ****************************************************************
  // entry sequence
  // ****************************************************************
  always_comb begin
    state_d = state_q;
    case (state_q)
      VIC_IDLE: if (take_any) state_d = VIC_FETCH;
      VIC_FETCH: if (vec_rd_valid) state_d = VIC_LOAD;
      VIC_LOAD: state_d = VIC_IDLE;
      default: state_d = VIC_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= VIC_IDLE;
      busy_q <= 1'b0;
      vec_rd_req_q <= 1'b0;
      vec_rd_addr_q <= 16'h0000;
      entry_load_q <= 1'b0;
      new_pc_q <= 16'h0000;
    end else begin
      state_q <= state_d;
      busy_q <= (state_d != VIC_IDLE);
      vec_rd_req_q <= (state_d == VIC_FETCH);
      entry_load_q <= (state_d == VIC_LOAD);
      if (take_any) vec_rd_addr_q <= sel_vec;
      if (state_q == VIC_FETCH && vec_rd_valid) new_pc_q <= vec_rd_data;
    end
  end

  // saves and new status/segment captured at acceptance
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      new_psw_q <= 16'h0000;
      new_csr_q <= 4'h0;
      return_addr_save_lvl1_q <= 16'h0000;
      return_addr_save_lvl2_q <= 16'h0000;
      segment_save_lvl1_q <= 4'h0;
      segment_save_lvl2_q <= 4'h0;
      status_save_lvl1_q <= 16'h0000;
      status_save_lvl2_q <= 16'h0000;
    end else if (take_nmi) begin
      return_addr_save_lvl2_q <= pc_in;
      status_save_lvl2_q <= psw_in;
      new_psw_q <= psw_lvl2;
      if (PROG_MEM_LARGE) segment_save_lvl2_q <= csr_in;
      new_csr_q <= PROG_MEM_LARGE ? CSR_ENTRY : csr_in;
    end else if (take_lvl1) begin
      return_addr_save_lvl1_q <= pc_in;
      status_save_lvl1_q <= psw_in;
      new_psw_q <= psw_lvl1;
      if (PROG_MEM_LARGE) segment_save_lvl1_q <= csr_in;
      new_csr_q <= PROG_MEM_LARGE ? CSR_ENTRY : csr_in;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  chk_mask_gating: assert property (
    take_mask |-> master_irq_enable && source_enable_bits[win_bit])
    else $error("maskable taken while gated off");
  chk_nmi_vector: assert property (
    take_nmi |=> vec_rd_addr_q == 16'h0008 && vec_rd_req_q)
    else $error("watchdog vector wrong");
  chk_fixed_order: assert property (
    take_mask && !level_ctrl_on |-> (cand & (win_onehot - 64'h1)) == '0)
    else $error("lower source number skipped");
  chk_level_order: assert property (
    take_mask && level_ctrl_on |-> !lvl_beaten)
    else $error("level arbitration inconsistent");
  chk_vec_fetch: assert property (
    take_any |=> vec_rd_req_q ##0 busy_q [*1] ##1 busy_q)
    else $error("vector fetch not started");
  chk_vec_addr: assert property (
    take_mask |=> vec_rd_addr_q ==
      16'h0008 + {9'h000, $past(win_bit) - 6'h04, 1'b0})
    else $error("maskable vector address wrong");
  chk_nmi_first: assert property (
    at_edge && pending_regs_q[0] |-> take_nmi && !take_mask && !take_trap)
    else $error("watchdog not first");
  chk_lvl1_save: assert property (
    take_mask |=> return_addr_save_lvl1_q == $past(pc_in)
      && status_save_lvl1_q == $past(psw_in))
    else $error("level-1 save wrong");
  chk_lvl1_psw: assert property (
    take_lvl1 |=> new_psw_q[1:0] == 2'h1 && !new_psw_q[PSW_MIE_BIT])
    else $error("level-1 status wrong");
  chk_nmi_psw: assert property (
    take_nmi |=> new_psw_q[1:0] == 2'h2
      && new_psw_q[PSW_MIE_BIT] == $past(psw_in[PSW_MIE_BIT]))
    else $error("level-2 status wrong");
  chk_level_lock: assert property (
    take_mask && level_ctrl_on |-> {1'b0, win_lvl} >= cil_top)
    else $error("lower level accepted");
  chk_pend_clear: assert property (
    take_mask && !irq_req[win_bit] |=> !pending_regs_q[$past(win_bit)])
    else $error("winner not cleared");
  chk_boundary: assert property (
    $rose(busy_q) |-> $past(instr_boundary))
    else $error("entry off boundary");
  chk_load_pulse: assert property (
    state_q == VIC_FETCH && vec_rd_valid |=> entry_load_q ##1 !entry_load_q)
    else $error("load strobe wrong");
  chk_req_hold: assert property (
    vec_rd_req_q && !vec_rd_valid |=> vec_rd_req_q)
    else $error("vector request dropped early");
  chk_seg_entry: assert property (
    take_any |=> new_csr_q == (PROG_MEM_LARGE ? CSR_ENTRY : $past(csr_in)))
    else $error("segment entry value wrong");
  chk_seg_save: assert property (
    take_lvl1 && PROG_MEM_LARGE |=> segment_save_lvl1_q == $past(csr_in))
    else $error("level-1 segment save wrong");
  chk_lvl2_save: assert property (
    take_nmi |=> return_addr_save_lvl2_q == $past(pc_in)
      && status_save_lvl2_q == $past(psw_in))
    else $error("level-2 save wrong");
  chk_trap_vector: assert property (
    take_trap |=> vec_rd_addr_q == $past(soft_trap_vec_addr))
    else $error("trap vector wrong");
  chk_level_write: assert property (
    !level_ctrl_on |=> $stable(level_select_regs))
    else $error("level register written while off");
  chk_level_mark: assert property (
    take_mask && level_ctrl_on |=>
      current_level_reg_q[$past(win_lvl)])
    else $error("current level not marked");

  cov_nmi: cover property (take_nmi);
  cov_mask_lvl: cover property (take_mask && level_ctrl_on);
  cov_trap: cover property (take_trap);
  cov_nmi_nested: cover property (busy_q && pending_regs_q[0] ##[1:20] take_nmi);
  cov_lvl_refused: cover property (at_edge && win_valid && level_ctrl_on
    && master_irq_enable && !lvl_ok);

endmodule : vic_top
`default_nettype wire
